/* File: design/ilss_regs.svh */
// Register map, field positions, codes and reset values of the input-latch sync block.
// Assumes byte addressing on a 32-bit AHB-Lite bus, one register per aligned word.
`ifndef ILSS_REGS_SVH
`define ILSS_REGS_SVH

// ==========================================================================
// Offsets
`define ILSS_OFF_CTRL        8'h00
`define ILSS_OFF_OUT_TYPE    8'h04
`define ILSS_OFF_IN_TYPE     8'h08
`define ILSS_OFF_SUPPORTED   8'h0c
`define ILSS_OFF_CYCLE_TIME  8'h10
`define ILSS_OFF_SHIFT_TIME  8'h14
`define ILSS_OFF_MIN_CYCLE   8'h18
`define ILSS_OFF_GET_CYCLE   8'h1c
`define ILSS_OFF_MEAS_CYCLE  8'h20
`define ILSS_OFF_TOO_SMALL   8'h24
`define ILSS_OFF_MISSED      8'h28
`define ILSS_OFF_SYNC_ERR    8'h2c
`define ILSS_OFF_IRQ_STAT    8'h30
`define ILSS_OFF_IRQ_MASK    8'h34

// ==========================================================================
// Fields
`define ILSS_CTRL_OUTPUTS    0
`define ILSS_CTRL_ENABLE     1
`define ILSS_CTRL_MISS_EN    2
`define ILSS_SUP_SM_BIT      1
`define ILSS_IRQ_LATCH       0
`define ILSS_IRQ_MISSED      1
`define ILSS_IRQ_TOO_SMALL   2

// ==========================================================================
// Codes and reset values
`define ILSS_TYPE_SYNC_BUF   8'h01
`define ILSS_TYPE_IN_FOLLOW  8'h22
`define ILSS_RST_CTRL        3'h0
`define ILSS_RST_CYCLE_TIME  32'h0000_0000
`define ILSS_RST_SHIFT_TIME  32'h0000_0000
`define ILSS_RST_IRQ_MASK    3'h0

`endif

/* File: design/ilss_pkg.sv */
// Types shared by the input-latch sync block.
// Constants live in ilss_regs.svh.
package ilss_pkg;

  typedef logic [31:0] ilss_word_t;

  typedef enum logic [1:0] {
    ILSS_IDLE,
    ILSS_WAIT_LATCH,
    ILSS_LATCHED
  } ilss_tstate_t;

  typedef struct packed {
    ilss_tstate_t state;
    logic [31:0]  cnt;
    logic [31:0]  period;
    logic         latch;
    logic         missed;
    logic         too_small;
  } ilss_tmr_st_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr_pend;
    logic [31:0] rdata;
    logic [2:0]  ctrl;
    logic [31:0] cycle_time;
    logic [31:0] shift_time;
    logic        get_cycle;
    logic [31:0] meas_cycle;
    logic [15:0] too_small_cnt;
    logic [15:0] missed_cnt;
    logic        sync_err;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
  } ilss_top_st_t;

endpackage

/* File: design/ilss_tmr_if.sv */
// Signals between the register block and the latch timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ilss_tmr_if;
  logic        cycle_start;
  logic [31:0] shift_time;
  logic [31:0] min_cycle;
  logic        latch;
  logic        missed;
  logic        too_small;
  logic [31:0] period;

  modport tmr (input cycle_start, shift_time, min_cycle,
               output latch, missed, too_small, period);
  modport ctl (output cycle_start, shift_time, min_cycle,
               input latch, missed, too_small, period);
endinterface

/* File: design/ilss_sync_edge.sv */
// Two-stage synchroniser with rising-edge pulse for a group of pins.
// Assumes pin pulses last at least two clock periods.
`timescale 1ns/10ps
module ilss_sync_edge #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_rise
);
  import ilss_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } ilss_sync_st_t;

  ilss_sync_st_t st_ff;
  ilss_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.meta = i_pin;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Edge taken between second stage and its delayed copy only
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_edge
      assign o_rise[g] = st_ff.sync[g] & ~st_ff.last[g];
    end
  endgenerate
endmodule

/* File: design/ilss_latch_timer.sv */
// Local-cycle timer: starts on a buffer event, fires the input latch at shift time.
// Assumes cycle_start is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
module ilss_latch_timer (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  ilss_tmr_if.tmr   tif
);
  import ilss_pkg::*;

  ilss_tmr_st_t st_ff;
  ilss_tmr_st_t nxt_st;
  logic [31:0]  cnt_inc;
  logic [31:0]  cnt_ahead;

  assign cnt_inc = st_ff.cnt + 32'h0000_0001;
  // Latch output is registered, so the decision is taken one cycle early
  assign cnt_ahead = st_ff.cnt + 32'h0000_0002;

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.latch     = 1'b0;
    nxt_st.missed    = 1'b0;
    nxt_st.too_small = 1'b0;
    if (st_ff.state != ILSS_IDLE)
      nxt_st.cnt = cnt_inc;
    if (tif.cycle_start)
    begin
      // New cycle start
      nxt_st.cnt = 32'h0000_0000;
      if (st_ff.state != ILSS_IDLE)
      begin
        nxt_st.period = cnt_inc;
        if (cnt_inc < tif.min_cycle)
          nxt_st.too_small = 1'b1;
      end
      if (st_ff.state == ILSS_WAIT_LATCH)
      begin
        // Shift reached past the event: latch now, count the overrun
        nxt_st.latch  = 1'b1;
        nxt_st.missed = 1'b1;
      end
      if (tif.shift_time <= 32'h0000_0001)
      begin
        nxt_st.latch = 1'b1;
        nxt_st.state = ILSS_LATCHED;
      end
      else
        nxt_st.state = ILSS_WAIT_LATCH;
    end
    else
    begin
      case (st_ff.state)
        ILSS_WAIT_LATCH:
        begin
          // Sample late, at shift time after cycle start
          if (cnt_ahead >= tif.shift_time)
          begin
            nxt_st.latch = 1'b1;
            nxt_st.state = ILSS_LATCHED;
          end
        end
        default:
        begin
          nxt_st.state = st_ff.state;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tif.latch     = st_ff.latch;
  assign tif.missed    = st_ff.missed;
  assign tif.too_small = st_ff.too_small;
  assign tif.period    = st_ff.period;
endmodule

/* File: design/ilss_top.sv */
// Input-latch shift synchroniser with AHB-Lite register slave.
// Assumes buffer-event pins are asynchronous pulses of two or more clocks.
`timescale 1ns/10ps
`include "ilss_regs.svh"
module ilss_top #(
  parameter logic [31:0] MIN_CYCLE = 32'h0000_0010
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire ilss_pkg::ilss_word_t hwdata,
  input  wire logic              hready,
  output ilss_pkg::ilss_word_t   hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              i_output_buffer_event,
  input  wire logic              i_input_buffer_event,
  output logic                   o_cycle_start,
  output logic                   o_input_latch,
  output logic                   o_irq
);
  import ilss_pkg::*;

  // ==========================================================================
  // Event capture
  logic [1:0]   ev_rise;
  logic         out_ev;
  logic         in_ev;
  logic         cyc_ff;
  logic         nxt_cyc;
  ilss_top_st_t st_ff;
  ilss_top_st_t nxt_st;

  ilss_sync_edge #(
    .WIDTH (2)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     ({i_input_buffer_event, i_output_buffer_event}),
    .o_rise    (ev_rise)
  );

  assign out_ev = ev_rise[0];
  assign in_ev  = ev_rise[1];

  // Event choice follows the outputs-present bit
  always_comb
  begin
    nxt_cyc = 1'b0;
    if (st_ff.ctrl[`ILSS_CTRL_ENABLE])
    begin
      if (st_ff.ctrl[`ILSS_CTRL_OUTPUTS])
        nxt_cyc = out_ev;
      else
        nxt_cyc = in_ev;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      cyc_ff <= 1'b0;
    else
      cyc_ff <= nxt_cyc;
  end

  // ==========================================================================
  // Latch timer
  ilss_tmr_if tif ();

  assign tif.cycle_start = cyc_ff;
  assign tif.shift_time  = st_ff.shift_time;
  assign tif.min_cycle   = MIN_CYCLE;

  ilss_latch_timer u_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .tif       (tif)
  );

  // ==========================================================================
  // Register read decode
  function automatic logic [31:0] rd_word(input logic [7:0] a, input ilss_top_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == `ILSS_OFF_CTRL)
      w = {29'h0000_0000, s.ctrl};
    else if (a == `ILSS_OFF_OUT_TYPE)
      w = {24'h00_0000, `ILSS_TYPE_SYNC_BUF};
    else if (a == `ILSS_OFF_IN_TYPE)
    begin
      if (s.ctrl[`ILSS_CTRL_OUTPUTS])
        w = {24'h00_0000, `ILSS_TYPE_IN_FOLLOW};
      else
        w = {24'h00_0000, `ILSS_TYPE_SYNC_BUF};
    end
    else if (a == `ILSS_OFF_SUPPORTED)
      w = 32'h0000_0001 << `ILSS_SUP_SM_BIT;
    else if (a == `ILSS_OFF_CYCLE_TIME)
      w = s.cycle_time;
    else if (a == `ILSS_OFF_SHIFT_TIME)
      w = s.shift_time;
    else if (a == `ILSS_OFF_MIN_CYCLE)
      w = MIN_CYCLE;
    else if (a == `ILSS_OFF_GET_CYCLE)
      w = {31'h0000_0000, s.get_cycle};
    else if (a == `ILSS_OFF_MEAS_CYCLE)
      w = s.meas_cycle;
    else if (a == `ILSS_OFF_TOO_SMALL)
      w = {16'h0000, s.too_small_cnt};
    else if (a == `ILSS_OFF_MISSED)
      w = {16'h0000, s.missed_cnt};
    else if (a == `ILSS_OFF_SYNC_ERR)
      w = {31'h0000_0000, s.sync_err};
    else if (a == `ILSS_OFF_IRQ_STAT)
      w = {29'h0000_0000, s.irq_stat};
    else if (a == `ILSS_OFF_IRQ_MASK)
      w = {29'h0000_0000, s.irq_mask};
    return w;
  endfunction

  // ==========================================================================
  // Bus slave and register state
  logic        addr_ok;
  logic [2:0]  irq_ev;
  logic [2:0]  irq_clr;
  logic        wr_hit;

  // Whole-word transfers only; others are taken but leave state alone
  assign addr_ok = hsel & hready & htrans[1] & (hsize == 3'h2);
  assign wr_hit  = st_ff.wr_pend;
  assign irq_ev  = {tif.too_small, tif.missed, tif.latch};

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.wr_pend = 1'b0;
    irq_clr        = 3'h0;

    if (addr_ok)
    begin
      nxt_st.addr    = haddr[7:0];
      nxt_st.wr_pend = hwrite;
      if (!hwrite)
        nxt_st.rdata = rd_word(haddr[7:0], st_ff);
    end

    if (wr_hit)
    begin
      if (st_ff.addr == `ILSS_OFF_CTRL)
        nxt_st.ctrl = hwdata[2:0];
      else if (st_ff.addr == `ILSS_OFF_CYCLE_TIME)
        nxt_st.cycle_time = hwdata;
      else if (st_ff.addr == `ILSS_OFF_SHIFT_TIME)
        nxt_st.shift_time = hwdata;
      else if (st_ff.addr == `ILSS_OFF_GET_CYCLE)
        nxt_st.get_cycle = hwdata[0];
      else if (st_ff.addr == `ILSS_OFF_IRQ_STAT)
        irq_clr = hwdata[2:0];
      else if (st_ff.addr == `ILSS_OFF_IRQ_MASK)
        nxt_st.irq_mask = hwdata[2:0];
    end

    // Period moves only at a cycle start; following it avoids a stale copy
    if (st_ff.get_cycle)
      nxt_st.meas_cycle = tif.period;

    // Counters saturate so software never sees a wrap to zero
    if (tif.too_small && st_ff.too_small_cnt != 16'hffff)
      nxt_st.too_small_cnt = st_ff.too_small_cnt + 16'h0001;

    if (st_ff.ctrl[`ILSS_CTRL_MISS_EN])
    begin
      if (tif.missed)
      begin
        if (st_ff.missed_cnt != 16'hffff)
          nxt_st.missed_cnt = st_ff.missed_cnt + 16'h0001;
        nxt_st.sync_err = 1'b1;
      end
      else if (tif.latch)
        nxt_st.sync_err = 1'b0;
    end
    else
      nxt_st.sync_err = 1'b0;

    // Set wins over a simultaneous write-one clear
    nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_ff            <= '0;
      st_ff.ctrl       <= `ILSS_RST_CTRL;
      st_ff.cycle_time <= `ILSS_RST_CYCLE_TIME;
      st_ff.shift_time <= `ILSS_RST_SHIFT_TIME;
      st_ff.irq_mask   <= `ILSS_RST_IRQ_MASK;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================================
  // Outputs
  assign hrdata        = st_ff.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign o_cycle_start = cyc_ff;
  assign o_input_latch = tif.latch;
  assign o_irq         = |(st_ff.irq_stat & st_ff.irq_mask);
endmodule

/* File: bench/ilss_asserts.sv */
// Checker on the ports of the input-latch sync top.
// Assumes one clock domain and a constant-ready bus slave.
`timescale 1ns/10ps
`include "ilss_regs.svh"
module ilss_asserts #(
  parameter logic [31:0] MIN_CYCLE = 32'h0000_0010
) (
  input logic                 i_sys_clk,
  input logic                 i_rst,
  input logic                 hsel,
  input logic [31:0]          haddr,
  input logic [1:0]           htrans,
  input logic                 hwrite,
  input logic [2:0]           hsize,
  input logic                 hready,
  input ilss_pkg::ilss_word_t hrdata,
  input logic                 i_output_buffer_event,
  input logic                 i_input_buffer_event,
  input logic                 o_cycle_start,
  input logic                 o_input_latch,
  input logic                 o_irq
);
  import ilss_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // Read decode
  logic rd;
  logic ev;
  logic [7:0] a;
  assign rd = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
  assign ev = i_output_buffer_event || i_input_buffer_event;
  assign a = haddr[7:0];
  // ==========
  // Properties
  cs_pulse_a: assert property (o_cycle_start |=> !o_cycle_start)
    else $error("cycle start longer than one cycle");
  cs_cause_a: assert property ($rose(o_cycle_start) |-> $past(ev, 3) || $past(ev, 4)
    || $past(ev, 5)) else $error("cycle start without event");
  latch_pulse_a: assert property (o_input_latch |=> !o_input_latch)
    else $error("latch longer than one cycle");
  out_type_a: assert property (rd && a == `ILSS_OFF_OUT_TYPE |=> hrdata == 32'h1)
    else $error("output type code wrong");
  in_type_a: assert property (rd && a == `ILSS_OFF_IN_TYPE |=> hrdata inside {32'h1, 32'h22})
    else $error("input type code wrong");
  supp_bit_a: assert property (rd && a == `ILSS_OFF_SUPPORTED |=> hrdata[1])
    else $error("supported bit clear");
  min_cyc_a: assert property (rd && a == `ILSS_OFF_MIN_CYCLE |=> hrdata == MIN_CYCLE)
    else $error("minimum cycle wrong");
  unmapped_read_a: assert property (rd && a > 8'h34 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  cover property (o_input_latch);
  cover property (o_irq);
  cover property ($rose(o_cycle_start));
endmodule
bind ilss_top ilss_asserts #(.MIN_CYCLE(MIN_CYCLE)) u_ilss_asserts (.i_sys_clk, .i_rst,
  .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .i_output_buffer_event,
  .i_input_buffer_event, .o_cycle_start, .o_input_latch, .o_irq);

/* File: bench/ilss_fb_master.sv */
// Model of the fieldbus master raising buffer events.
// Assumes the bench calls send and spaces the events.
`timescale 1ns/10ps
module ilss_fb_master (
  input  wire logic i_sys_clk,
  output logic      o_output_buffer_event,
  output logic      o_input_buffer_event
);
  initial o_output_buffer_event = 1'b0;
  initial o_input_buffer_event = 1'b0;
  // ==========
  // Three clocks, so the synchroniser cannot miss it
  task automatic send(input bit inp);
    @(posedge i_sys_clk);
    if (inp) o_input_buffer_event <= 1'b1;
    else o_output_buffer_event <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    o_input_buffer_event <= 1'b0;
    o_output_buffer_event <= 1'b0;
  endtask
endmodule

/* File: bench/ilss_top_tb.sv */
// Self-checking bench for the input-latch sync block.
// Assumes zero-wait bus slave; event pins come from the master model.
`timescale 1ns/10ps
`include "ilss_regs.svh"
module ilss_top_tb;
  import ilss_pkg::*;
  typedef struct {logic [7:0] a; ilss_word_t e;} ilss_row_t;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  ilss_word_t  hwdata = 32'h0;
  ilss_word_t  hrdata;
  logic        hreadyout, hresp, ev_out, ev_in, cs, lat, irq;
  int          error_cnt = 0;
  int          n_compared = 0;
  ilss_row_t   rows[10] = '{'{`ILSS_OFF_OUT_TYPE, 32'h1}, '{`ILSS_OFF_IN_TYPE, 32'h1},
    '{`ILSS_OFF_SUPPORTED, 32'h2}, '{`ILSS_OFF_MIN_CYCLE, 32'h10}, '{`ILSS_OFF_CTRL, 32'h0},
    '{`ILSS_OFF_CYCLE_TIME, 32'h0}, '{`ILSS_OFF_SHIFT_TIME, 32'h0}, '{`ILSS_OFF_MISSED, 32'h0},
    '{`ILSS_OFF_IRQ_MASK, 32'h0}, '{8'h40, 32'h0}};
  always #2 i_sys_clk = ~i_sys_clk;
  ilss_top u_ilss_top (.i_sys_clk, .i_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .i_output_buffer_event(ev_out),
    .i_input_buffer_event(ev_in), .o_cycle_start(cs), .o_input_latch(lat), .o_irq(irq));
  ilss_fb_master u_ilss_fb_master (.i_sys_clk, .o_output_buffer_event(ev_out),
    .o_input_buffer_event(ev_in));
  // ==========
  // Tasks
  task automatic chk(input string nm, input ilss_word_t exp, input ilss_word_t got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input ilss_word_t d,
                     output ilss_word_t q);
    @(posedge i_sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input ilss_word_t e);
    ilss_word_t q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [7:0] a, input ilss_word_t d);
    ilss_word_t q;
    bus(1'b1, a, d, q);
  endtask
  // Bounded wait, so a dead pulse ends in a compare, not a hang
  task automatic wt(input bit l, output int n);
    n = 0;
    do
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    while ((l ? lat : cs) !== 1'b1 && n < 300);
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========
  // Sequence
  initial
  begin
    int n;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (rows[i])
      rdc("reset read", rows[i].a, rows[i].e);
    chk("okay response", 32'h0, 32'(hresp));
    wr(`ILSS_OFF_CYCLE_TIME, 32'h64);
    rdc("cycle time", `ILSS_OFF_CYCLE_TIME, 32'h64);
    wr(`ILSS_OFF_GET_CYCLE, 32'h1);
    rdc("get cycle", `ILSS_OFF_GET_CYCLE, 32'h1);
    wr(`ILSS_OFF_CTRL, 32'h3);
    rdc("input type", `ILSS_OFF_IN_TYPE, 32'h22);
    wr(`ILSS_OFF_SHIFT_TIME, 32'h5);
    wr(`ILSS_OFF_IRQ_MASK, 32'h1);
    fork
      u_ilss_fb_master.send(1'b0);
      wt(1'b0, n);
    join
    chk("cycle start", 32'h1, 32'(cs));
    wt(1'b1, n);
    chk("latch delay", 32'h5, 32'(n));
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("irq raised", 32'h1, 32'(irq));
    wr(`ILSS_OFF_IRQ_MASK, 32'h0);
    @(posedge i_sys_clk);
    #1;
    chk("irq masked", 32'h0, 32'(irq));
    rdc("latch flag", `ILSS_OFF_IRQ_STAT, 32'h1);
    wr(`ILSS_OFF_IRQ_STAT, 32'h1);
    rdc("flag cleared", `ILSS_OFF_IRQ_STAT, 32'h0);
    fork
      u_ilss_fb_master.send(1'b1);
      wt(1'b0, n);
    join
    chk("input event ignored", 32'h0, 32'(cs));
    wr(`ILSS_OFF_CTRL, 32'h6);
    wr(`ILSS_OFF_SHIFT_TIME, 32'h28);
    fork
      u_ilss_fb_master.send(1'b1);
      wt(1'b0, n);
    join
    chk("input event used", 32'h1, 32'(cs));
    repeat (10) @(posedge i_sys_clk);
    u_ilss_fb_master.send(1'b1);
    repeat (8) @(posedge i_sys_clk);
    rdc("sync error", `ILSS_OFF_SYNC_ERR, 32'h1);
    rdc("missed count", `ILSS_OFF_MISSED, 32'h1);
    repeat (60) @(posedge i_sys_clk);
    rdc("sync error clear", `ILSS_OFF_SYNC_ERR, 32'h0);
    // Second start came 14 cycles after the first, below the 16-cycle minimum
    rdc("too small count", `ILSS_OFF_TOO_SMALL, 32'h1);
    rdc("measured cycle", `ILSS_OFF_MEAS_CYCLE, 32'he);
    rdc("event flags", `ILSS_OFF_IRQ_STAT, 32'h7);
    // ==========
    // Mid-run reset, then a byte-sized write that must be ignored
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rdc("ctrl after reset", `ILSS_OFF_CTRL, 32'h0);
    rdc("missed after reset", `ILSS_OFF_MISSED, 32'h0);
    chk("irq after reset", 32'h0, 32'(irq));
    hsize <= 3'h0;
    wr(`ILSS_OFF_SHIFT_TIME, 32'h9);
    hsize <= 3'h2;
    rdc("byte write ignored", `ILSS_OFF_SHIFT_TIME, 32'h0);
    wrap_up();
  end
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule
